// [nvm_regs_pkg.sv]
// Constants and carrier types for the backlight register and NVM block
package nvm_regs_pkg;

  // Register offsets
  localparam logic [7:0] CHIP_IDENTITY_ADDR = 8'h03;
  localparam logic [7:0] OUTPUT_FORCE_FULL_ADDR = 8'h04;
  localparam logic [7:0] DIE_HEAT_UPPER_ADDR = 8'h05;
  localparam logic [7:0] DIE_HEAT_LOWER_ADDR = 8'h06;
  localparam logic [7:0] NVM_CONTROL_ADDR = 8'h72;
  localparam logic [7:0] CFG_FIRST_ADDR = 8'hA0;
  localparam logic [7:0] CFG_LAST_ADDR = 8'hA7;
  localparam int CFG_COUNT = 8;

  // Reset values
  localparam logic [7:0] OUTPUT_FORCE_FULL_RST = 8'h00;
  localparam logic [7:0] DIE_HEAT_RST = 8'h00;
  localparam logic [7:0] NVM_CONTROL_RST = 8'h00;

  // Field positions
  localparam int NVM_IDLE_FLAG_POS = 7;
  localparam int NVM_ARM_BIT_POS = 2;
  localparam int NVM_BURN_BIT_POS = 1;
  localparam int NVM_RELOAD_BIT_POS = 0;
  localparam int HEAT_WIDTH = 11;
  localparam int HEAT_LOW_BITS = 3;
  localparam int HEAT_LOWER_POS = 5;

  // Default factory image of the configuration bytes, first byte lowest
  localparam logic [63:0] NVM_FACTORY_IMAGE = 64'h2D644F287BBFF57F;

  // Timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int HOST_WAIT_MS = 200;
  localparam int NVM_OP_TIME_MS = 10;
  // Longest time, rounded down
  localparam longint NVM_OP_CYCLES_DEF =
    (longint'(NVM_OP_TIME_MS) * 64'd1000000000) / CLK_PERIOD_PS;
  localparam longint HOST_WAIT_CYCLES =
    (longint'(HOST_WAIT_MS) * 64'd1000000000) / CLK_PERIOD_PS;

  // Register access request from the serial interface back end
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage

// [backlight_nvm_ctrl_regs.sv]
// Register bank: identity, output forcing, die heat, NVM control
`timescale 1ns/1ps

module backlight_nvm_ctrl_regs
  import nvm_regs_pkg::*;
#(
  parameter int OUT_COUNT = 4,
  parameter logic [7:0] ID_VALUE = 8'h5A, // Arbitrary identity value
  parameter longint OP_CYCLES = NVM_OP_CYCLES_DEF
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Register access
  input wire reg_req_t reg_req_i,
  output logic [7:0] rd_data_o,
  // Sensor
  input wire logic [HEAT_WIDTH-1:0] die_heat_i,
  // Device controls
  output logic [OUT_COUNT-1:0] force_full_o,
  output logic [8*CFG_COUNT-1:0] cfg_o,
  output logic nvm_idle_o
);

  // Idle, copying one byte a cycle, then waiting out the cell time
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_COPY,
    ST_WAIT
  } nvm_state_t;

  ////////////////////////////////////////////////////////////////////////
  // Non-volatile store

  typedef logic [7:0] cfg_bytes_t [CFG_COUNT];

  // Splits a packed image into bytes, lowest address in the low byte
  function automatic cfg_bytes_t unpack_image(
    input logic [8*CFG_COUNT-1:0] img
  );
    cfg_bytes_t b;
    for (int i = 0; i < CFG_COUNT; i++) begin
      b[i] = img[8*i +: 8];
    end
    return b;
  endfunction

  // Not touched by reset: reset stands for a power cycle. Starting
  // contents are given at declaration so only the burn writes the array.
  cfg_bytes_t nvm_mem = unpack_image(NVM_FACTORY_IMAGE);

  ////////////////////////////////////////////////////////////////////////
  // State

  nvm_state_t state_q, state_d;
  logic load_dir_q, load_dir_d;
  logic [2:0] idx_q, idx_d;
  logic [31:0] timer_q, timer_d;
  logic armed_q;
  logic [7:0] ctrl_q;
  logic [7:0] force_q;
  logic [HEAT_LOW_BITS-1:0] heat_low_q;
  logic [7:0] cfg_q [CFG_COUNT];
  logic [7:0] rd_data_q;

  ////////////////////////////////////////////////////////////////////////
  // Decode

  function automatic logic is_cfg(input logic [7:0] a);
    return (a >= CFG_FIRST_ADDR) && (a <= CFG_LAST_ADDR);
  endfunction

  // Write strobes
  wire logic wr_ctrl = reg_req_i.wr && (reg_req_i.addr == NVM_CONTROL_ADDR);
  wire logic wr_force =
    reg_req_i.wr && (reg_req_i.addr == OUTPUT_FORCE_FULL_ADDR);
  wire logic wr_cfg = reg_req_i.wr && is_cfg(reg_req_i.addr);
  wire logic [2:0] cfg_idx = reg_req_i.addr[2:0];

  // Read strobes
  wire logic rd_upper =
    reg_req_i.rd && (reg_req_i.addr == DIE_HEAT_UPPER_ADDR);
  wire logic idle = (state_q == ST_IDLE);
  wire logic req_burn = reg_req_i.wdata[NVM_BURN_BIT_POS];
  wire logic req_reload = reg_req_i.wdata[NVM_RELOAD_BIT_POS];
  // Only a request after a stored arm starts anything
  wire logic start_op =
    wr_ctrl && idle && armed_q && (req_burn || req_reload);
  wire logic [31:0] op_last = 32'(OP_CYCLES - 1);

  // Sequencer step decode, shared by the copy processes below
  wire logic copy_step = (state_q == ST_COPY);
  wire logic burn_step = copy_step && !load_dir_q;
  wire logic reload_step = copy_step && load_dir_q;
  wire logic copy_last = (idx_q == 3'(CFG_COUNT - 1));
  // Compare with >= so a shortened count can never wrap the timer
  wire logic wait_done = (timer_q >= op_last);

  ////////////////////////////////////////////////////////////////////////
  // Read mux

  wire logic [7:0] upper_rd = die_heat_i[HEAT_WIDTH-1:HEAT_LOW_BITS];
  // Lower bits come from the latch, never live, so the pair is coherent
  wire logic [7:0] lower_rd = {heat_low_q, 5'h00};
  // Bits 6:3 are reserved and read as zero
  logic [7:0] ctrl_rd;
  always_comb begin
    ctrl_rd = {5'h00, ctrl_q[2:0]};
    ctrl_rd[NVM_IDLE_FLAG_POS] = idle;
  end

  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (is_cfg(reg_req_i.addr)) begin
      rd_mux = cfg_q[cfg_idx];
    end
    case (reg_req_i.addr)
      CHIP_IDENTITY_ADDR: rd_mux = ID_VALUE;
      OUTPUT_FORCE_FULL_ADDR: rd_mux = force_q;
      DIE_HEAT_UPPER_ADDR: rd_mux = upper_rd;
      DIE_HEAT_LOWER_ADDR: rd_mux = lower_rd;
      NVM_CONTROL_ADDR: rd_mux = ctrl_rd;
      default: ;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // NVM sequencer

  always_comb begin
    state_d = state_q;
    load_dir_d = load_dir_q;
    idx_d = idx_q;
    timer_d = timer_q;
    case (state_q)
      ST_IDLE: begin
        if (start_op) begin
          state_d = ST_COPY;
          load_dir_d = req_reload && !req_burn;
          idx_d = 3'h0;
        end
      end
      ST_COPY: begin
        // Eight bytes, one per cycle, lowest address first
        idx_d = idx_q + 3'h1;
        if (copy_last) begin
          state_d = ST_WAIT;
          timer_d = 32'h0;
        end
      end
      ST_WAIT: begin
        // Finishes well inside the host wait window
        timer_d = timer_q + 32'h1;
        if (wait_done) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // Reset enters a reload so every startup restores the stored image
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_q <= ST_COPY;
      load_dir_q <= 1'b1;
      idx_q <= 3'h0;
      timer_q <= 32'h0;
    end else begin
      state_q <= state_d;
      load_dir_q <= load_dir_d;
      idx_q <= idx_d;
      timer_q <= timer_d;
    end
  end

  // Burn stores the live registers; a burn during reload is impossible
  always_ff @(posedge core_clk_i) begin
    if (burn_step) begin
      nvm_mem[idx_q] <= cfg_q[idx_q];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ctrl_q <= NVM_CONTROL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= reg_req_i.wdata;
    end
  end

  // A start uses up the arm; a fresh arm is needed for the next one
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      armed_q <= 1'b0;
    end else if (start_op) begin
      armed_q <= 1'b0;
    end else if (wr_ctrl && reg_req_i.wdata[NVM_ARM_BIT_POS]) begin
      armed_q <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      force_q <= OUTPUT_FORCE_FULL_RST;
    end else if (wr_force) begin
      force_q <= reg_req_i.wdata;
    end
  end

  // Latched on the upper read so a later lower read matches it
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      heat_low_q <= '0;
    end else if (rd_upper) begin
      heat_low_q <= die_heat_i[HEAT_LOW_BITS-1:0];
    end
  end

  // Read data holds until the next read strobe
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rd_data_q <= 8'h00;
    end else if (reg_req_i.rd) begin
      rd_data_q <= rd_mux;
    end
  end

  // Volatile copy; cleared by reset, then refilled from NVM
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < CFG_COUNT; i++) begin
        cfg_q[i] <= 8'h00;
      end
    end else if (reload_step) begin
      // A config write in the same cycle loses to the reload
      cfg_q[idx_q] <= nvm_mem[idx_q];
    end else if (wr_cfg) begin
      cfg_q[cfg_idx] <= reg_req_i.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  logic [OUT_COUNT-1:0] force_out_q;
  logic [8*CFG_COUNT-1:0] cfg_out_q;
  logic idle_out_q;
  // Registered force and config outputs cost one cycle of lag behind the registers; the idle pin has none
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      force_out_q <= '0;
    end else begin
      force_out_q <= force_q[OUT_COUNT-1:0];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cfg_out_q <= '0;
    end else begin
      for (int i = 0; i < CFG_COUNT; i++) begin
        cfg_out_q[8*i +: 8] <= cfg_q[i];
      end
    end
  end

  // Taken from the next state so the pin lines up with the read-back
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      idle_out_q <= 1'b0;
    end else begin
      idle_out_q <= state_d == ST_IDLE;
    end
  end

  assign force_full_o = force_out_q;
  assign cfg_o = cfg_out_q;
  assign nvm_idle_o = idle_out_q;
  assign rd_data_o = rd_data_q;

endmodule

// [nvm_regs_chk_assertions.sv]
// Assertion checker for the backlight register bank
`timescale 1ns/1ps
module nvm_regs_chk
  import nvm_regs_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire reg_req_t reg_req_i,
  input wire logic [7:0] rd_data_o,
  input wire logic [HEAT_WIDTH-1:0] die_heat_i,
  input wire logic [3:0] force_full_o,
  input wire logic [63:0] cfg_o,
  input wire logic nvm_idle_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  wire logic [7:0] a = reg_req_i.addr;
  wire logic [7:0] d = reg_req_i.wdata;
  wire logic wr = reg_req_i.wr;
  wire logic rd = reg_req_i.rd;
  wire logic ctl = wr && a == NVM_CONTROL_ADDR;
  wire logic go = ctl && d[1:0] != 2'h0;
  logic [2:0] lo_q;
  logic arm_q;
  //////////////////////////////////////////////////////////
  always_ff @(posedge core_clk_i)
    if (rst_i) lo_q <= 3'h0;
    else if (rd && a == DIE_HEAT_UPPER_ADDR) lo_q <= die_heat_i[2:0];
  // Arm survives until a start consumes it
  always_ff @(posedge core_clk_i)
    if (rst_i) arm_q <= 1'b0;
    else if (go && arm_q && nvm_idle_o) arm_q <= 1'b0;
    else if (ctl && d[2]) arm_q <= 1'b1;
  //////////////////////////////////////////////////////////
  property p_force;
    wr && a == OUTPUT_FORCE_FULL_ADDR
      |-> ##2 force_full_o == $past(d[3:0], 2); endproperty
  a_force: assert property (p_force) else $error("force");
  property p_upper; rd && a == DIE_HEAT_UPPER_ADDR
    |=> rd_data_o == $past(die_heat_i[10:3]); endproperty
  a_upper: assert property (p_upper) else $error("upper");
  property p_lower; rd && a == DIE_HEAT_LOWER_ADDR
    |=> rd_data_o == {$past(lo_q), 5'h00}; endproperty
  a_lower: assert property (p_lower) else $error("lower");
  property p_ctl; rd && a == NVM_CONTROL_ADDR
    |=> rd_data_o[7:3] == {$past(nvm_idle_o), 4'h0}; endproperty
  a_ctl: assert property (p_ctl) else $error("ctrl read");
  property p_back; $fell(nvm_idle_o) |-> ##[1:40] nvm_idle_o; endproperty
  a_back: assert property (p_back) else $error("busy long");
  property p_cfg; wr && a[7:3] == 5'h14 && nvm_idle_o
    |-> ##2 cfg_o[8*$past(a[2:0], 2) +: 8] == $past(d, 2); endproperty
  a_cfg: assert property (p_cfg) else $error("cfg");
  property p_arm; go && arm_q && nvm_idle_o
    |-> ##[1:2] !nvm_idle_o; endproperty
  a_arm: assert property (p_arm) else $error("no start");
  property p_noarm; go && !arm_q && nvm_idle_o
    |=> nvm_idle_o [*3]; endproperty
  a_noarm: assert property (p_noarm) else $error("start");
  c_go: cover property (go && arm_q);
  c_rise: cover property ($rose(nvm_idle_o));
  c_low: cover property (rd && a == DIE_HEAT_LOWER_ADDR);
endmodule
bind backlight_nvm_ctrl_regs nvm_regs_chk chk (
  .core_clk_i, .rst_i, .reg_req_i, .rd_data_o,
  .die_heat_i, .force_full_o, .cfg_o, .nvm_idle_o
);

// [host_model.sv]
// Host controller model for the register port
`timescale 1ns/1ps
module host_model
  import nvm_regs_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic nvm_idle_i,
  output reg_req_t req_o
);
  initial req_o = '0;
  task automatic acc(input logic w, input logic [7:0] a, d);
    @(posedge core_clk_i);
    req_o <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge core_clk_i);
    // Released lines flip so stale values never look valid
    req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  task automatic wait_idle(output logic ok);
    ok = 1'b0;
    for (int n = 0; n < 100 && !ok; n++) begin
      @(posedge core_clk_i);
      ok = nvm_idle_i;
    end
  endtask
  // Bench-only use
  task automatic nvm_op(input logic [7:0] op, output logic ok);
    acc(1'b1, 8'h01, 8'h05);
    acc(1'b1, NVM_CONTROL_ADDR, 8'h04);
    acc(1'b1, NVM_CONTROL_ADDR, op);
    repeat (2) @(posedge core_clk_i);
    wait_idle(ok);
    acc(1'b1, NVM_CONTROL_ADDR, 8'h00);
  endtask
endmodule

// [backlight_nvm_ctrl_regs_tb.sv]
// Self-checking bench for the backlight register bank
`timescale 1ns/1ps
module backlight_nvm_ctrl_regs_tb
  import nvm_regs_pkg::*;
;
  // Arbitrary identity value
  localparam logic [7:0] TB_ID = 8'hC3;
  logic core_clk_i, rst_i, nvm_idle_o, ok;
  logic rd_q = 1'b0;
  logic [10:0] die_heat_i, h;
  logic [7:0] rd_data_o, lf;
  logic [3:0] force_full_o;
  logic [63:0] cfg_o, img;
  reg_req_t reg_req_i;
  logic [7:0] exp_q[$];
  int fails, checked;
  backlight_nvm_ctrl_regs #(.OP_CYCLES(20), .ID_VALUE(TB_ID)) DUT (
    .core_clk_i, .rst_i,
    .reg_req_i, .rd_data_o, .die_heat_i, .force_full_o, .cfg_o,
    .nvm_idle_o);
  host_model host (.core_clk_i, .nvm_idle_i(nvm_idle_o),
    .req_o(reg_req_i));
  //////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input string n, input logic [63:0] e, s);
    checked++;
    if (s !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic rd(input logic [7:0] a, e);
    exp_q.push_back(e);
    host.acc(1'b0, a, 8'h00);
  endtask
  task automatic final_report();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge core_clk_i) begin
    if (rd_q) chk("rd_data", 64'(exp_q.pop_front()), 64'(rd_data_o));
    rd_q <= reg_req_i.rd;
  end
  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  initial begin
    #40000;
    fails++;
    final_report();
  end
  //////////////////////////////////////////////////////////
  initial begin
    rst_i = 1'b1;
    lf = 8'h51;
    die_heat_i = 11'h000;
    repeat (4) @(posedge core_clk_i);
    rst_i <= 1'b0;
    host.wait_idle(ok);
    chk("boot", NVM_FACTORY_IMAGE, cfg_o);
    rd(CHIP_IDENTITY_ADDR, TB_ID);
    lf = lfsr(lf);
    host.acc(1'b1, OUTPUT_FORCE_FULL_ADDR, lf);
    rd(OUTPUT_FORCE_FULL_ADDR, lf);
    chk("force", 64'(lf[3:0]), 64'(force_full_o));
    h = {lfsr(lf), lf[2:0]};
    die_heat_i <= h;
    rd(DIE_HEAT_UPPER_ADDR, h[10:3]);
    die_heat_i <= ~h;
    rd(DIE_HEAT_LOWER_ADDR, {h[2:0], 5'h00});
    $display("force and heat done");
    for (int k = 0; k < 8; k++) begin
      lf = lfsr(lf);
      img[8*k +: 8] = lf;
      host.acc(1'b1, CFG_FIRST_ADDR + 8'(k), lf);
    end
    repeat (2) @(posedge core_clk_i);
    chk("cfg", img, cfg_o);
    host.acc(1'b1, NVM_CONTROL_ADDR, 8'h02);
    rd(NVM_CONTROL_ADDR, 8'h82);
    host.acc(1'b1, NVM_CONTROL_ADDR, 8'h00);
    host.nvm_op(8'h02, ok);
    chk("burn", 64'(ok), 64'h1);
    chk("idle", 64'h1, 64'(nvm_idle_o));
    rd(NVM_CONTROL_ADDR, 8'h80);
    host.acc(1'b1, 8'hA3, ~img[31:24]);
    host.nvm_op(8'h01, ok);
    chk("reload", img, cfg_o);
    $display("nvm done");
    rst_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    rst_i <= 1'b0;
    host.wait_idle(ok);
    chk("reboot", img, cfg_o);
    $display("restart done");
    final_report();
  end
endmodule
